/* File: core/tpfec_pkg.sv */
// Overview of operation
// - ESF mode counts CRC6 mismatches as path errors
// - D4 counts Ft errors, Fs when enabled
// - T1 path counter halts during loss of sync
// - E1 path counter counts CRC4 checksum errors
// - E1 path stops on FAS/CRC4 loss, not CAS
// - Path count bytes at 44h high, 45h low
// - Out-of-sync select counts out-of-sync multiframes always
// - Framing-bit select counts Ft/FPS errors, sync loss halts
// - E1 counts FAS word errors unless sync lost
// - E1 ignores FAS errors while searching for alignment
// - Out-of-sync count bytes at 46h high, 47h low
// - E-bit counter: E1 CRC4 only, frames 13, 15
// - Each E-bit received as zero adds one
// - E-bit counter stops on FAS/CRC4 loss, not CAS
// - E-bit count bytes at 48h high, 49h low
// - Counters hold one second of worst-case errors
// - Auto boundary latches counts and clears counters
// - Manual bit rising edge latches counts two clocks later
// - Counters saturate at maximum, never wrap
package tpfec_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PATH_VIOLATION_COUNT_HIGH_OFS = 8'h44;
    localparam logic [7:0] PATH_VIOLATION_COUNT_LOW_OFS = 8'h45;
    localparam logic [7:0] FRAMES_OUT_OF_SYNC_COUNT_HIGH_OFS = 8'h46;
    localparam logic [7:0] FRAMES_OUT_OF_SYNC_COUNT_LOW_OFS = 8'h47;
    localparam logic [7:0] FAR_END_BLOCK_ERROR_COUNT_HIGH_OFS = 8'h48;
    localparam logic [7:0] FAR_END_BLOCK_ERROR_COUNT_LOW_OFS = 8'h49;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // Count layout
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int HIGH_BYTE_LSB = 8;
    localparam int LOW_BYTE_LSB = 0;
    localparam int FAS_ERR_MAX_PER_SEC = 4000;
    localparam int BLOCK_ERR_MAX_PER_SEC = 1000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int SECOND_MS = 1000;
    localparam int SECOND_CYCLES = SECOND_MS * 1000 * CLK_MHZ;
    localparam int T1_SHORT_FRAMES = 333;
    localparam int E1_SHORT_FRAMES = 500;

    // ------------------------------------------------------------
    // E1 CRC4 multiframe frames carrying E-bits
    // ------------------------------------------------------------
    localparam logic [3:0] EBIT_FRAME_A = 4'hd;
    localparam logic [3:0] EBIT_FRAME_B = 4'hf;

    typedef enum logic {
        TPFEC_ACC_AUTO,
        TPFEC_ACC_MANUAL
    } tpfec_acc_mode_t;

endpackage

/* File: core/tpfec_cnt_if.sv */
`timescale 1ns/1ps
interface tpfec_cnt_if #(parameter int W = 16);
    logic inc;
    logic update;
    logic [W-1:0] snap;
    modport cnt (input inc, input update, output snap);
    modport ctl (output inc, output update, input snap);
endinterface

/* File: core/tpfec_sat_counter.sv */
`timescale 1ns/1ps
module tpfec_sat_counter #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Event and snapshot
    tpfec_cnt_if.cnt cnt
);
    logic [W-1:0] run_q;
    logic [W-1:0] snap_q;
    logic [W-1:0] run_d;

    // Fewer bits would leave no room between clear and saturation
    if (W < 2)
    begin
        $error("tpfec_sat_counter: W too small");
    end

    // ------------------------------------------------------------
    // Running count
    // ------------------------------------------------------------
    // Holding at all-ones keeps a flooded line from reading as quiet
    always_comb
    begin
        run_d = run_q;
        if (cnt.inc && run_q != '1)
        begin
            run_d = run_q + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            run_q <= '0;
        end
        else if (cnt.update)
        begin
            run_q <= '0;
        end
        else
        begin
            run_q <= run_d;
        end
    end

    // ------------------------------------------------------------
    // Snapshot
    // ------------------------------------------------------------
    // An event in the update cycle lands in the closing snapshot
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            snap_q <= '0;
        end
        else if (cnt.update)
        begin
            snap_q <= run_d;
        end
    end

    assign cnt.snap = snap_q;

endmodule

/* File: core/tpfec_top.sv */
`timescale 1ns/1ps
module tpfec_top
    import tpfec_pkg::*;
#(
    parameter int SEC_CYCLES = tpfec_pkg::SECOND_CYCLES,
    parameter int T1_FRAMES = tpfec_pkg::T1_SHORT_FRAMES,
    parameter int E1_FRAMES = tpfec_pkg::E1_SHORT_FRAMES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode and counter configuration
    input wire logic e1_mode,
    input wire logic t1_receive_framing_select,
    input wire logic e1_crc4_enable,
    input wire logic signaling_framing_error_report_enable,
    input wire logic out_of_sync_or_framing_bit_select,
    input wire logic counter_update_period_select,
    input wire logic accumulation_mode_select,
    input wire logic manual_counter_update,
    // Framer timing
    input wire logic frame_strobe,
    input wire logic multiframe_strobe,
    input wire logic [3:0] mf_frame_number,
    // Synchronizer status
    input wire logic receive_loss_of_sync,
    input wire logic multiframe_out_of_sync,
    input wire logic fas_align_lost,
    input wire logic crc4_mf_align_lost,
    input wire logic fas_searching,
    input wire logic cas_mf_searching,
    input wire logic crc4_mf_searching,
    // Error events
    input wire logic crc6_error,
    input wire logic ft_error,
    input wire logic fs_error,
    input wire logic fps_error,
    input wire logic crc4_error,
    input wire logic fas_word_error,
    input wire logic si_bit_strobe,
    input wire logic si_bit,
    // Host read port
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    output logic [7:0] reg_rdata_q,
    output logic counts_updated_q
);
    import tpfec_pkg::*;

    // Timer widths follow the parameters, so a short test period costs no logic
    localparam int SEC_W = $clog2(SEC_CYCLES + 1);
    localparam int FRM_W = $clog2(((T1_FRAMES > E1_FRAMES) ? T1_FRAMES : E1_FRAMES) + 1);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // A period under two cycles would keep the update strobe high for good
    if (SEC_CYCLES < 2 || T1_FRAMES < 1 || E1_FRAMES < 1)
    begin
        $error("tpfec_top: update periods out of range");
    end
    if ((2 ** CNT_W) - 1 < FAS_ERR_MAX_PER_SEC || (2 ** CNT_W) - 1 < BLOCK_ERR_MAX_PER_SEC)
    begin
        $error("tpfec_top: count width cannot hold one second");
    end

    tpfec_cnt_if #(.W(CNT_W)) path_if ();
    tpfec_cnt_if #(.W(CNT_W)) fos_if ();
    tpfec_cnt_if #(.W(CNT_W)) ebit_if ();

    logic path_inc_q;
    logic fos_inc_q;
    logic ebit_inc_q;
    logic update_q;
    logic manual_prev_q;
    logic [SEC_W-1:0] sec_cnt_q;
    logic [FRM_W-1:0] frm_cnt_q;
    logic path_ev;
    logic fos_ev;
    logic ebit_ev;
    logic auto_tick;
    logic manual_tick;
    tpfec_acc_mode_t acc_mode;

    function automatic logic is_ebit_frame(input logic [3:0] fnum);
        is_ebit_frame = (fnum == EBIT_FRAME_A) || (fnum == EBIT_FRAME_B);
    endfunction

    // ------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------
    always_comb
    begin
        path_ev = 1'b0;
        if (e1_mode)
        begin
            path_ev = crc4_error && !fas_align_lost && !crc4_mf_align_lost;
        end
        else if (!receive_loss_of_sync)
        begin
            if (t1_receive_framing_select)
            begin
                path_ev = crc6_error;
            end
            else
            begin
                path_ev = ft_error || (signaling_framing_error_report_enable && fs_error);
            end
        end
    end

    always_comb
    begin
        fos_ev = 1'b0;
        if (e1_mode)
        begin
            fos_ev = fas_word_error && !receive_loss_of_sync
                && !fas_searching && !cas_mf_searching && !crc4_mf_searching;
        end
        else if (out_of_sync_or_framing_bit_select)
        begin
            fos_ev = multiframe_strobe && multiframe_out_of_sync;
        end
        else if (!receive_loss_of_sync)
        begin
            fos_ev = t1_receive_framing_select ? fps_error : ft_error;
        end
    end

    // Frame number qualifies the Si bit so stray strobes cannot count
    always_comb
    begin
        ebit_ev = e1_mode && e1_crc4_enable && si_bit_strobe
            && is_ebit_frame(mf_frame_number) && !si_bit
            && !fas_align_lost && !crc4_mf_align_lost;
    end

    // One register stage keeps the long qualify paths off the counters
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            path_inc_q <= 1'b0;
            fos_inc_q <= 1'b0;
            ebit_inc_q <= 1'b0;
        end
        else
        begin
            path_inc_q <= path_ev;
            fos_inc_q <= fos_ev;
            ebit_inc_q <= ebit_ev;
        end
    end

    // ------------------------------------------------------------
    // Update timing
    // ------------------------------------------------------------
    // Manual edges are ignored in automatic mode, and the timers in manual mode
    assign acc_mode = accumulation_mode_select ? TPFEC_ACC_MANUAL : TPFEC_ACC_AUTO;

    // Both timers free-run so switching period never waits a full second
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sec_cnt_q <= '0;
        end
        else if (sec_cnt_q == SEC_W'(SEC_CYCLES - 1))
        begin
            sec_cnt_q <= '0;
        end
        else
        begin
            sec_cnt_q <= sec_cnt_q + 1'b1;
        end
    end

    // A mode change mid-period may cut one period short; the >= compare recovers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            frm_cnt_q <= '0;
        end
        else if (frame_strobe)
        begin
            if (frm_cnt_q >= FRM_W'((e1_mode ? E1_FRAMES : T1_FRAMES) - 1))
            begin
                frm_cnt_q <= '0;
            end
            else
            begin
                frm_cnt_q <= frm_cnt_q + 1'b1;
            end
        end
    end

    always_comb
    begin
        if (counter_update_period_select)
        begin
            auto_tick = frame_strobe
                && frm_cnt_q >= FRM_W'((e1_mode ? E1_FRAMES : T1_FRAMES) - 1);
        end
        else
        begin
            auto_tick = sec_cnt_q == SEC_W'(SEC_CYCLES - 1);
        end
    end

    assign manual_tick = manual_counter_update && !manual_prev_q;

    // Registering the trigger gives every counter the same clean update edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            manual_prev_q <= 1'b0;
            update_q <= 1'b0;
        end
        else
        begin
            manual_prev_q <= manual_counter_update;
            unique case (acc_mode)
                TPFEC_ACC_AUTO: update_q <= auto_tick;
                TPFEC_ACC_MANUAL: update_q <= manual_tick;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    assign path_if.inc = path_inc_q;
    assign path_if.update = update_q;
    assign fos_if.inc = fos_inc_q;
    assign fos_if.update = update_q;
    assign ebit_if.inc = ebit_inc_q;
    assign ebit_if.update = update_q;

    tpfec_sat_counter #(.W(CNT_W)) u_path_violation_counter (
        .clk(clk),
        .rst_n(rst_n),
        .cnt(path_if.cnt)
    );

    tpfec_sat_counter #(.W(CNT_W)) u_frames_out_of_sync_counter (
        .clk(clk),
        .rst_n(rst_n),
        .cnt(fos_if.cnt)
    );

    tpfec_sat_counter #(.W(CNT_W)) u_far_end_block_error_counter (
        .clk(clk),
        .rst_n(rst_n),
        .cnt(ebit_if.cnt)
    );

    // Snapshot lands one clock after update_q, so flag it a clock later
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            counts_updated_q <= 1'b0;
        end
        else
        begin
            counts_updated_q <= update_q;
        end
    end

    // ------------------------------------------------------------
    // Host read port
    // ------------------------------------------------------------
    // Read-only: there is no write path into the snapshots
    // Unmapped offsets read zero so a stray address never shows old data
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reg_rdata_q <= REG_RESET;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                PATH_VIOLATION_COUNT_HIGH_OFS:
                    reg_rdata_q <= path_if.snap[HIGH_BYTE_LSB +: 8];
                PATH_VIOLATION_COUNT_LOW_OFS:
                    reg_rdata_q <= path_if.snap[LOW_BYTE_LSB +: 8];
                FRAMES_OUT_OF_SYNC_COUNT_HIGH_OFS:
                    reg_rdata_q <= fos_if.snap[HIGH_BYTE_LSB +: 8];
                FRAMES_OUT_OF_SYNC_COUNT_LOW_OFS:
                    reg_rdata_q <= fos_if.snap[LOW_BYTE_LSB +: 8];
                FAR_END_BLOCK_ERROR_COUNT_HIGH_OFS:
                    reg_rdata_q <= ebit_if.snap[HIGH_BYTE_LSB +: 8];
                FAR_END_BLOCK_ERROR_COUNT_LOW_OFS:
                    reg_rdata_q <= ebit_if.snap[LOW_BYTE_LSB +: 8];
                default:
                    reg_rdata_q <= UNMAPPED_READ;
            endcase
        end
    end

endmodule

/* File: tb/tpfec_props.sv */
`timescale 1ns/1ps
module tpfec_props #(
    parameter int SEC_CYCLES = 50,
    parameter int T1_FRAMES = 3,
    parameter int E1_FRAMES = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Update control
    input wire logic accumulation_mode_select,
    input wire logic counter_update_period_select,
    input wire logic manual_counter_update,
    // Host side
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata_q,
    input wire logic counts_updated_q
);
    // ----
    // Helpers
    // ----
    int gap_q;
    logic seen_q;
    logic mchg_q;
    always_ff @(posedge clk)
    begin
        gap_q <= (!rst_n || counts_updated_q) ? 0 : gap_q + 1;
        seen_q <= rst_n && (seen_q || counts_updated_q);
        // A period is only judged when the mode held since the last update
        mchg_q <= rst_n && !counts_updated_q && (mchg_q || $changed(accumulation_mode_select)
            || $changed(counter_update_period_select));
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_mrise;
        accumulation_mode_select && $rose(manual_counter_update);
    endsequence
    sequence s_latch;
        ##2 counts_updated_q;
    endsequence
    manual_latch_a: assert property (s_mrise |-> s_latch)
        else $error("manual update late");
    manual_cause_a: assert property (counts_updated_q && accumulation_mode_select
        && $past(accumulation_mode_select, 3) |-> $past(manual_counter_update, 2)
        && !$past(manual_counter_update, 3))
        else $error("update without manual edge");
    upd_single_a: assert property (counts_updated_q |=> !counts_updated_q)
        else $error("update flag too long");
    auto_period_a: assert property (counts_updated_q && seen_q && !mchg_q
        && !accumulation_mode_select && !counter_update_period_select
        |-> gap_q == SEC_CYCLES - 1)
        else $error("one second period wrong");
    read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
        else $error("read data moved");
    unmapped_a: assert property (reg_rd && (reg_addr < 8'h44 || reg_addr > 8'h49)
        |=> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    reset_clear_a: assert property ($rose(rst_n) |-> reg_rdata_q == 8'h00
        && !counts_updated_q)
        else $error("outputs not cleared");
    snap_reset_a: assert property (reg_rd && !seen_q && !counts_updated_q
        |=> reg_rdata_q == 8'h00)
        else $error("snapshot not zero");
endmodule

bind tpfec_top tpfec_props #(
    .SEC_CYCLES(SEC_CYCLES),
    .T1_FRAMES(T1_FRAMES),
    .E1_FRAMES(E1_FRAMES)
) u_props (
    .clk(clk), .rst_n(rst_n), .accumulation_mode_select(accumulation_mode_select),
    .counter_update_period_select(counter_update_period_select),
    .manual_counter_update(manual_counter_update), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata_q(reg_rdata_q), .counts_updated_q(counts_updated_q)
);

/* File: tb/tpfec_framer_model.sv */
`timescale 1ns/1ps
module tpfec_framer_model #(
    parameter int FRAME_LEN = 4
) (
    // Clock
    input wire logic clk,
    // Bench requests
    input wire logic ebit_zero,
    input wire logic oos_req,
    // Frame timing and E-bits
    output logic frame_strobe,
    output logic multiframe_strobe,
    output logic [3:0] mf_frame_number,
    output logic si_bit_strobe,
    output logic si_bit,
    // Tallies of what was sent
    output int ebits_sent,
    output int oos_sent
);
    int phase_q;
    logic ebit_frame;
    always_ff @(posedge clk)
    begin
        phase_q <= (phase_q + 1) % (16 * FRAME_LEN);
    end
    assign mf_frame_number = 4'(phase_q / FRAME_LEN);
    assign si_bit_strobe = (phase_q % FRAME_LEN) == 0;
    assign frame_strobe = (phase_q % FRAME_LEN) == FRAME_LEN - 1;
    assign multiframe_strobe = frame_strobe && (mf_frame_number == 4'hf);
    assign ebit_frame = (mf_frame_number == 4'hd) || (mf_frame_number == 4'hf);
    // Zeros go out in every frame, so a counter blind to the frame number shows
    // Off the strobe the line keeps toggling
    assign si_bit = si_bit_strobe ? !ebit_zero : phase_q[0];
    always_ff @(posedge clk)
    begin
        if (si_bit_strobe && !si_bit && ebit_frame)
            ebits_sent <= ebits_sent + 1;
        if (multiframe_strobe && oos_req)
            oos_sent <= oos_sent + 1;
    end
endmodule

/* File: tb/tpfec_bench.sv */
`timescale 1ns/1ps
module tpfec_bench;
    import tpfec_pkg::*;
    localparam int SECS = 50;
    localparam int T1F = 3;
    localparam int E1F = 5;
    localparam int FLEN = 4;
    // ----
    // Stimulus and observation
    // ----
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic e1 = 1'b0, esf = 1'b1, crc4_en = 1'b1, sfe = 1'b0, oos_sel = 1'b0;
    logic per_sel = 1'b0, acc = 1'b1, mcu = 1'b0, oos = 1'b0, ebz = 1'b0;
    logic reg_rd = 1'b0, rd_seen = 1'b0, cu, fs, mfs, sis, sib;
    logic [5:0] ev = 6'h00, inh = 6'h00;
    logic [7:0] reg_addr = 8'h00, rdata;
    logic [3:0] mfn;
    logic [7:0] expq[$];
    int ebits_sent, oos_sent, failures = 0, checks = 0;
    always #4 clk = ~clk;
    tpfec_top #(.SEC_CYCLES(SECS), .T1_FRAMES(T1F), .E1_FRAMES(E1F)) dut (
        .clk(clk), .rst_n(rst_n), .e1_mode(e1), .t1_receive_framing_select(esf),
        .e1_crc4_enable(crc4_en), .signaling_framing_error_report_enable(sfe),
        .out_of_sync_or_framing_bit_select(oos_sel), .counter_update_period_select(per_sel),
        .accumulation_mode_select(acc), .manual_counter_update(mcu), .frame_strobe(fs),
        .multiframe_strobe(mfs), .mf_frame_number(mfn), .receive_loss_of_sync(inh[2]),
        .multiframe_out_of_sync(oos), .fas_align_lost(inh[0]), .crc4_mf_align_lost(inh[1]),
        .fas_searching(inh[3]), .cas_mf_searching(inh[5]), .crc4_mf_searching(inh[4]),
        .crc6_error(ev[0]), .ft_error(ev[1]), .fs_error(ev[2]), .fps_error(ev[3]),
        .crc4_error(ev[4]), .fas_word_error(ev[5]), .si_bit_strobe(sis), .si_bit(sib),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata_q(rdata), .counts_updated_q(cu)
    );
    tpfec_framer_model #(.FRAME_LEN(FLEN)) u_framer (
        .clk(clk), .ebit_zero(ebz), .oos_req(oos), .frame_strobe(fs), .multiframe_strobe(mfs),
        .mf_frame_number(mfn), .si_bit_strobe(sis), .si_bit(sib),
        .ebits_sent(ebits_sent), .oos_sent(oos_sent)
    );
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        expq.push_back(e[15:8]);
        @(posedge clk);
        reg_addr <= a + 8'h01;
        expq.push_back(e[7:0]);
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic hit(input logic [5:0] m, input int n);
        ev <= m;
        repeat (n) @(posedge clk);
        ev <= 6'h00;
        @(posedge clk);
    endtask
    task automatic upd;
        repeat (3) @(posedge clk);
        mcu <= 1'b1;
        repeat (3) @(posedge clk);
        mcu <= 1'b0;
        @(posedge clk);
    endtask
    task automatic win(input logic e, output int d);
        int s;
        s = e ? ebits_sent : oos_sent;
        ebz <= e;
        oos <= !e;
        repeat (16 * FLEN + 8) @(posedge clk);
        ebz <= 1'b0;
        oos <= 1'b0;
        @(posedge clk);
        d = (e ? ebits_sent : oos_sent) - s;
    endtask
    task automatic gap(input int e);
        int n;
        for (n = 0; n < 300 && cu !== 1'b1; n++)
            @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 300 && cu !== 1'b1; n++)
            @(posedge clk);
        chk(16'(n), 16'(e));
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (rd_seen)
            chk(16'(rdata), 16'(expq.pop_front()));
        rd_seen <= reg_rd;
    end
    // ----
    // Sequence
    // ----
    initial
    begin
        int d, n, k;
        void'($urandom(18104));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 4; k++)
            rd16(8'h44 + 8'(2 * k), 16'h0000);
        $display("reset test done");
        n = $urandom_range(20, 1);
        hit(6'h01, n);
        hit(6'h08, 3);
        upd;
        rd16(8'h44, 16'(n));
        rd16(8'h46, 16'h0003);
        hit(6'h01, 4);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd16(8'h44, 16'h0000);
        upd;
        rd16(8'h44, 16'h0000);
        $display("mid-run reset test done");
        inh <= 6'h04;
        hit(6'h09, 4);
        inh <= 6'h00;
        upd;
        rd16(8'h44, 16'h0000);
        rd16(8'h46, 16'h0000);
        esf <= 1'b0;
        hit(6'h02, 2);
        hit(6'h04, 3);
        upd;
        rd16(8'h44, 16'h0002);
        rd16(8'h46, 16'h0002);
        sfe <= 1'b1;
        hit(6'h04, 3);
        upd;
        rd16(8'h44, 16'h0003);
        rd16(8'h46, 16'h0000);
        $display("t1 framing test done");
        oos_sel <= 1'b1;
        inh <= 6'h04;
        win(1'b0, d);
        inh <= 6'h00;
        upd;
        rd16(8'h46, 16'(d));
        $display("t1 out of sync test done");
        e1 <= 1'b1;
        for (k = 0; k < 7; k++)
        begin
            inh <= (k < 6) ? 6'(1 << k) : 6'h00;
            hit(6'h30, 3);
            win(1'b1, d);
            inh <= 6'h00;
            upd;
            if (k < 2 || k > 4)
                rd16(8'h44, (k < 2) ? 16'h0000 : 16'h0003);
            if (k > 1)
                rd16(8'h46, (k < 6) ? 16'h0000 : 16'h0003);
            if (k < 2 || k > 4)
                rd16(8'h48, (k < 2) ? 16'h0000 : 16'(d));
        end
        crc4_en <= 1'b0;
        win(1'b1, d);
        upd;
        rd16(8'h48, 16'h0000);
        crc4_en <= 1'b1;
        $display("e1 test done");
        hit(6'h10, 65540);
        upd;
        rd16(8'h44, 16'hffff);
        $display("saturation test done");
        acc <= 1'b0;
        gap(SECS);
        hit(6'h10, 5);
        for (n = 0; n < 100 && cu !== 1'b1; n++)
            @(posedge clk);
        rd16(8'h44, 16'h0005);
        per_sel <= 1'b1;
        gap(E1F * FLEN);
        e1 <= 1'b0;
        gap(T1F * FLEN);
        $display("auto update test done");
        end_of_test;
    end
    initial
    begin
        repeat (90000) @(posedge clk);
        failures++;
        end_of_test;
    end
endmodule
